// ==== gbt_pkg.sv ====
package gbt_pkg;
   // Register byte addresses on the APB bus.
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_GATE  = 8'h04;
   localparam logic [7:0] ADDR_LOW   = 8'h08;
   localparam logic [7:0] ADDR_HIGH  = 8'h0c;
   localparam logic [7:0] ADDR_FLAGS = 8'h10;
   localparam logic [7:0] ADDR_CSYNC = 8'h14;
   // Timer control register fields.
   localparam int CTRL_ON   = 0;
   localparam int CTRL_OSEL = 1;
   localparam int CTRL_SYNC = 2;
   localparam int CTRL_SOSC = 3;
   localparam int CTRL_PS   = 4;
   localparam int CTRL_CS   = 6;
   // Gate control register fields.
   localparam int GATE_SS   = 0;
   localparam int GATE_VAL  = 2;
   localparam int GATE_GO   = 3;
   localparam int GATE_SPM  = 4;
   localparam int GATE_TM   = 5;
   localparam int GATE_POL  = 6;
   localparam int GATE_EN   = 7;
   // Flag register fields, cleared by writing a one.
   localparam int FLAG_OVF  = 0;
   localparam int FLAG_GEV  = 1;
   // Reset values, and the largest count.
   localparam logic [7:0]  CTRL_RST  = 8'h00;
   localparam logic [7:0]  GATE_RST  = 8'h00;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   // Last phase of the four system clocks per instruction cycle.
   localparam logic [1:0]  INSTR_LAST = 2'h3;
   // Clock source codes.
   typedef enum logic [1:0] {
      GBT_CS_INSTR = 2'h0,
      GBT_CS_SYSTEM_OSCILLATOR_CLOCK  = 2'h1,
      GBT_CS_EXT   = 2'h2,
      GBT_CS_LFOSC = 2'h3
   } gbt_cs_t;
   // Gate source codes.
   typedef enum logic [1:0] {
      GBT_GS_PIN  = 2'h0,
      GBT_GS_WRAP = 2'h1,
      GBT_GS_CMP1 = 2'h2,
      GBT_GS_CMP2 = 2'h3
   } gbt_gs_t;
endpackage : gbt_pkg

// ==== gbt_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser for signals from outside the clock domain.
module gbt_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_i,
   input  wire logic             srst_i,
   input  wire logic             ce_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync;

   // A zero-width synchroniser has nothing to carry.
   if (WIDTH < 1) begin : g_bad_width
      $error("gbt_sync needs a width of at least one.");
   end

   // The first stage feeds only the second stage.
   always_comb begin
      next_stage1 = ce_i ? async_i : stage1;
      next_sync   = ce_i ? stage1 : sync_o;
   end

   // Both stages clear under reset.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= next_stage1;
         sync_o <= next_sync;
      end
   end
endmodule : gbt_sync

// ==== gbt_timer.sv ====
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module gbt_timer #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clock_i,
   input  wire logic              srst_i,
   input  wire logic              ce_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic              ext_clk_i,
   input  wire logic              lfosc_i,
   input  wire logic              sosc_clk_i,
   input  wire logic              gate_pin_i,
   input  wire logic              cmp1_i,
   input  wire logic              cmp2_i,
   input  wire logic              wrap_pulse_i,
   input  wire logic              sleep_i,
   output logic                   sosc_enable_o,
   output logic [15:0]            count_o,
   output logic                   gate_value_o
);
   logic [5:0] pins_s;
   logic [5:0] pins_d;
   logic [7:0] ctrl, gate_ctrl;
   logic [1:0] csync, phase, next_phase;
   logic [2:0] presc, next_presc;
   logic       ovf_flag, gev_flag, tff, sp_active, g2_d, cmp_t1, cmp_t2;
   logic [7:0] next_ctrl, next_gate_ctrl;
   logic [1:0] next_csync;
   logic [15:0] next_count;
   logic       next_ovf, next_gev, next_tff, next_sp, next_gval;
   logic       next_cmp_t1, next_cmp_t2;
   logic [31:0] next_prdata;
   logic       next_pready, next_pslverr;
   logic       acc, wr, wr_lo, wr_hi, wr_any, hit, src_tick, pre_tick, inc;
   logic       gsrc, g1, g2, rise2, fall2, run, ge, awake;
   logic       ext_rise, lf_rise, so_rise;
   logic       gsrc_prev_g1, next_g1_d;

   // Address bits 7:0 are decoded, so a narrower bus cannot work.
   if (ADDR_W < 8) begin : g_bad_addr
      $error("gbt_timer needs at least eight address bits.");
   end

   // Converts a prescale code into the last value of the prescale count.
   function automatic logic [2:0] presc_last(input logic [1:0] code);
      presc_last = 3'((4'h1 << code) - 4'h1);
   endfunction : presc_last

   // Bring every pin, oscillator and comparator level into the clock domain.
   // Unsynchronised counting is emulated in this domain, so the sync bit
   // only decides whether counting goes on while the processor sleeps.
   gbt_sync #(.WIDTH(6)) u_sync (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .ce_i    (ce_i),
      .async_i ({lfosc_i, cmp2_i, cmp1_i, gate_pin_i, sosc_clk_i,
                 ext_clk_i}),
      .sync_o  (pins_s)
   );

   // Rising edges of the synchronised clock inputs.
   assign ext_rise = pins_s[0] & ~pins_d[0];
   assign so_rise  = pins_s[1] & ~pins_d[1];
   assign lf_rise  = pins_s[5] & ~pins_d[5];

   // Bus decode; a write or read takes effect when pready is sampled high.
   assign acc    = ce_i & psel_i & penable_i & pready_o;
   assign wr     = acc & pwrite_i;
   assign wr_lo  = wr & (paddr_i[7:0] == gbt_pkg::ADDR_LOW);
   assign wr_hi  = wr & (paddr_i[7:0] == gbt_pkg::ADDR_HIGH);
   assign wr_any = wr_lo | wr_hi;

   // Picks the enabled source edge, then the prescaler divides it.
   always_comb begin
      unique case (gbt_pkg::gbt_cs_t'(ctrl[gbt_pkg::CTRL_CS +: 2]))
         gbt_pkg::GBT_CS_INSTR: src_tick = (phase == gbt_pkg::INSTR_LAST);
         gbt_pkg::GBT_CS_SYSTEM_OSCILLATOR_CLOCK:  src_tick = 1'b1;
         gbt_pkg::GBT_CS_EXT:   src_tick = ctrl[gbt_pkg::CTRL_OSEL] ?
                                           so_rise : ext_rise;
         gbt_pkg::GBT_CS_LFOSC: src_tick = lf_rise;
      endcase
   end

   // Sleep stops counting unless the external source runs unsynchronised.
   assign awake = ~sleep_i |
      ((ctrl[gbt_pkg::CTRL_CS +: 2] == gbt_pkg::GBT_CS_EXT) &
       ctrl[gbt_pkg::CTRL_SYNC]);
   assign pre_tick = src_tick & awake &
      (presc == presc_last(ctrl[gbt_pkg::CTRL_PS +: 2]));
   assign run = ctrl[gbt_pkg::CTRL_ON];
   assign ge  = gate_ctrl[gbt_pkg::GATE_EN];
   assign inc = ce_i & pre_tick & run & (~ge | gate_value_o);

   // Gate source mux; comparators may be resampled on counter ticks.
   always_comb begin
      unique case (gbt_pkg::gbt_gs_t'(gate_ctrl[gbt_pkg::GATE_SS +: 2]))
         gbt_pkg::GBT_GS_PIN:  gsrc = pins_s[2];
         gbt_pkg::GBT_GS_WRAP: gsrc = wrap_pulse_i;
         gbt_pkg::GBT_GS_CMP1: gsrc = csync[0] ? cmp_t1 : pins_s[3];
         gbt_pkg::GBT_GS_CMP2: gsrc = csync[1] ? cmp_t2 : pins_s[4];
      endcase
   end

   // Polarity, then toggle flip-flop, then single-pulse window.
   assign g1    = gate_ctrl[gbt_pkg::GATE_POL] ? gsrc : ~gsrc;
   assign g2    = gate_ctrl[gbt_pkg::GATE_TM] ? tff : g1;
   assign rise2 = g2 & ~g2_d;
   assign fall2 = ~g2 & g2_d;

   // Next state of the gate unit.
   always_comb begin
      next_tff = tff;
      if (!gate_ctrl[gbt_pkg::GATE_TM]) begin
         next_tff = 1'b0;
      end else if (g1 && !gsrc_prev_g1) begin
         next_tff = ~tff;
      end
      next_sp = sp_active;
      if (!gate_ctrl[gbt_pkg::GATE_SPM]) begin
         next_sp = 1'b0;
      end else if (sp_active && fall2) begin
         next_sp = 1'b0;
      end else if (gate_ctrl[gbt_pkg::GATE_GO] && rise2) begin
         next_sp = 1'b1;
      end
      next_gval = gate_ctrl[gbt_pkg::GATE_SPM] ? (g2 & next_sp) : g2;
      next_cmp_t1 = pre_tick ? pins_s[3] : cmp_t1;
      next_cmp_t2 = pre_tick ? pins_s[4] : cmp_t2;
   end

   // Previous polarity-corrected gate level, for the toggle edge detector.
   assign next_g1_d = g1;

   // Next state of the counter, prescaler and flags.
   always_comb begin
      next_phase = phase + 2'h1;
      next_presc = presc;
      if (wr_any) begin
         next_presc = 3'h0;
      end else if (src_tick && awake) begin
         next_presc = pre_tick ? 3'h0 : presc + 3'h1;
      end
      next_count = inc ? count_o + 16'h0001 : count_o;
      if (wr_lo) begin
         next_count[7:0] = pwdata_i[7:0];
      end
      if (wr_hi) begin
         next_count[15:8] = pwdata_i[7:0];
      end
      next_ovf = ovf_flag;
      if (wr && paddr_i[7:0] == gbt_pkg::ADDR_FLAGS &&
          pwdata_i[gbt_pkg::FLAG_OVF]) begin
         next_ovf = 1'b0;
      end
      if (inc && count_o == gbt_pkg::COUNT_MAX) begin
         next_ovf = 1'b1;
      end
      next_gev = gev_flag;
      if (wr && paddr_i[7:0] == gbt_pkg::ADDR_FLAGS &&
          pwdata_i[gbt_pkg::FLAG_GEV]) begin
         next_gev = 1'b0;
      end
      if (gate_value_o && !next_gval) begin
         next_gev = 1'b1;
      end
   end

   // Next state of the control registers and the bus answer.
   always_comb begin
      next_ctrl      = ctrl;
      next_gate_ctrl = gate_ctrl;
      next_csync     = csync;
      if (wr && paddr_i[7:0] == gbt_pkg::ADDR_CTRL) begin
         next_ctrl = pwdata_i[7:0];
      end
      if (wr && paddr_i[7:0] == gbt_pkg::ADDR_CSYNC) begin
         next_csync = pwdata_i[1:0];
      end
      if (gate_ctrl[gbt_pkg::GATE_SPM] && sp_active && fall2) begin
         next_gate_ctrl[gbt_pkg::GATE_GO] = 1'b0;
      end
      if (wr && paddr_i[7:0] == gbt_pkg::ADDR_GATE) begin
         next_gate_ctrl = pwdata_i[7:0];
         next_gate_ctrl[gbt_pkg::GATE_GO] = pwdata_i[gbt_pkg::GATE_GO] |
            (gate_ctrl[gbt_pkg::GATE_GO] & ~(sp_active & fall2));
      end
      next_gate_ctrl[gbt_pkg::GATE_VAL] = next_gval;
      next_pready  = psel_i & penable_i & ~pready_o;
      hit = 1'b1;
      next_prdata = 32'h0000_0000;
      unique case (paddr_i[7:0])
         gbt_pkg::ADDR_CTRL:  next_prdata[7:0] = ctrl;
         gbt_pkg::ADDR_GATE:  next_prdata[7:0] = gate_ctrl;
         gbt_pkg::ADDR_LOW:   next_prdata[7:0] = count_o[7:0];
         gbt_pkg::ADDR_HIGH:  next_prdata[7:0] = count_o[15:8];
         gbt_pkg::ADDR_FLAGS: next_prdata[1:0] = {gev_flag, ovf_flag};
         gbt_pkg::ADDR_CSYNC: next_prdata[1:0] = csync;
         default:             hit = 1'b0;
      endcase
      // Read data is captured in the first access cycle and then held.
      if (!next_pready) begin
         next_prdata = prdata_o;
      end
      next_pslverr = next_pready ? ~hit : 1'b0;
   end

   // Registers every group; clock enable low freezes all of it.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ctrl         <= gbt_pkg::CTRL_RST;
         gate_ctrl    <= gbt_pkg::GATE_RST;
         csync        <= 2'h0;
         count_o      <= gbt_pkg::COUNT_RST;
         phase        <= 2'h0;
         presc        <= 3'h0;
         ovf_flag     <= 1'b0;
         gev_flag     <= 1'b0;
         tff          <= 1'b0;
         sp_active    <= 1'b0;
         gate_value_o <= 1'b0;
         g2_d         <= 1'b0;
         gsrc_prev_g1 <= 1'b0;
         cmp_t1       <= 1'b0;
         cmp_t2       <= 1'b0;
         pins_d       <= 6'h00;
         prdata_o     <= 32'h0000_0000;
         pready_o     <= 1'b0;
         pslverr_o    <= 1'b0;
         sosc_enable_o <= 1'b0;
      end else if (ce_i) begin
         ctrl         <= next_ctrl;
         gate_ctrl    <= next_gate_ctrl;
         csync        <= next_csync;
         count_o      <= next_count;
         phase        <= next_phase;
         presc        <= next_presc;
         ovf_flag     <= next_ovf;
         gev_flag     <= next_gev;
         tff          <= next_tff;
         sp_active    <= next_sp;
         gate_value_o <= next_gval;
         g2_d         <= g2;
         gsrc_prev_g1 <= next_g1_d;
         cmp_t1       <= next_cmp_t1;
         cmp_t2       <= next_cmp_t2;
         pins_d       <= pins_s;
         prdata_o     <= next_prdata;
         pready_o     <= next_pready;
         pslverr_o    <= next_pslverr;
         sosc_enable_o <= next_ctrl[gbt_pkg::CTRL_SOSC];
      end
   end

   // Checks on the timing of counter, gate and flag behaviour.
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   sequence s_arm;
      ce_i && gate_ctrl[gbt_pkg::GATE_SPM] && gate_ctrl[gbt_pkg::GATE_GO]
      && !sp_active && rise2;
   endsequence
   sequence s_done;
      ce_i && gate_ctrl[gbt_pkg::GATE_SPM] && sp_active && fall2 && !wr;
   endsequence

   run_gate_a: assert property ((ce_i && !run && !wr_any) |=>
      count_o == $past(count_o)) else $error("Stopped counter moved.");
   byte_write_a: assert property (wr_lo |=>
      count_o[7:0] == $past(pwdata_i[7:0])) else $error("Low byte lost.");
   presc_clr_a: assert property (wr_any |=> presc == 3'h0)
      else $error("Prescaler not cleared by counter write.");
   roll_over_a: assert property ((inc && count_o == 16'hffff && !wr_any)
      |=> count_o == 16'h0000 && ovf_flag)
      else $error("Rollover did not set overflow.");
   gate_hold_a: assert property ((ce_i && ge && !gate_value_o && !wr_any)
      |=> count_o == $past(count_o))
      else $error("Counter moved with gate inactive.");
   toggle_clr_a: assert property ((ce_i && !gate_ctrl[gbt_pkg::GATE_TM])
      |=> !tff) else $error("Toggle flip-flop not held clear.");
   pulse_arm_a: assert property (s_arm |=> sp_active)
      else $error("Single pulse did not start.");
   pulse_done_a: assert property (s_done |=>
      !gate_ctrl[gbt_pkg::GATE_GO] && !sp_active)
      else $error("Single pulse did not finish.");
   gate_event_a: assert property ((ce_i && gate_value_o && !next_gval)
      |=> gev_flag) else $error("Gate event flag missed.");
   instr_rate_a: assert property ((inc && ctrl[gbt_pkg::CTRL_CS +: 2] ==
      gbt_pkg::GBT_CS_INSTR) |=> !inc [*3])
      else $error("Instruction-rate source counted too fast.");

   // Checks on bus answers, flags, sleep and the oscillator enable.
   hi_write_a: assert property (wr_hi |=>
      count_o[15:8] == $past(pwdata_i[7:0])) else $error("High byte lost.");
   bus_answer_a: assert property (
      (ce_i && psel_i && penable_i && !pready_o) |=> pready_o)
      else $error("Bus transfer not answered.");
   ovf_sticky_a: assert property (
      (ce_i && ovf_flag && !(wr && paddr_i[7:0] == gbt_pkg::ADDR_FLAGS))
      |=> ovf_flag) else $error("Overflow flag dropped by itself.");
   gev_sticky_a: assert property (
      (ce_i && gev_flag && !(wr && paddr_i[7:0] == gbt_pkg::ADDR_FLAGS))
      |=> gev_flag) else $error("Gate event flag dropped by itself.");
   presc_wrap_a: assert property ((pre_tick && ce_i && !wr_any) |=>
      presc == 3'h0) else $error("Prescaler did not restart.");
   sleep_halt_a: assert property (
      (ce_i && sleep_i && !ctrl[gbt_pkg::CTRL_SYNC] && !wr_any)
      |=> count_o == $past(count_o)) else $error("Counter ran in sleep.");
   sosc_follow_a: assert property (ce_i |=>
      sosc_enable_o == ctrl[gbt_pkg::CTRL_SOSC])
      else $error("Oscillator enable does not follow its bit.");
endmodule : gbt_timer

// ==== gbt_far_model.sv ====
`timescale 1ns/1ps
// Far side of the timer: count clocks, gate pin, comparators, wrap pulse.
module gbt_far_model (
   input  wire logic clock_i,
   output logic      ext_clk_o,
   output logic      lfosc_o,
   output logic      sosc_o,
   output logic      gate_o,
   output logic      cmp1_o,
   output logic      cmp2_o,
   output logic      wrap_o
);
   logic [5:0] line   = 6'h00;
   logic       wrap_q = 1'b0;

   // Clock lines stand low between bursts; gate lines keep their level.
   assign ext_clk_o = line[0];
   assign lfosc_o   = line[1];
   assign sosc_o    = line[2];
   assign gate_o    = line[3];
   assign cmp1_o    = line[4];
   assign cmp2_o    = line[5];
   assign wrap_o    = wrap_q;

   // Sends n pulses, each w cycles high and w cycles low.
   task automatic pulses(input int sel, input int n, input int w);
      for (int i = 0; i < n; i++) begin
         line[sel] <= 1'b1;
         repeat (w) @(posedge clock_i);
         line[sel] <= 1'b0;
         repeat (w) @(posedge clock_i);
      end
   endtask : pulses

   // Sets a line to a steady level.
   task automatic level(input int sel, input logic v);
      line[sel] <= v;
      @(posedge clock_i);
   endtask : level

   // Companion timer wrap: one cycle high, then low again.
   task automatic wrap_pulse;
      wrap_q <= 1'b1;
      @(posedge clock_i);
      wrap_q <= 1'b0;
      @(posedge clock_i);
   endtask : wrap_pulse
endmodule : gbt_far_model

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   typedef struct {
      logic [31:0] lo;
      logic [31:0] hi;
      logic        err;
   } gbt_note_t;

   logic        clock_i = 1'b0;
   logic        srst_i  = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic        sleep   = 1'b0;
   logic        ce      = 1'b1;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, ext_clk, lfosc, sosc, gpin;
   logic        cmp1, cmp2, wrap, sosc_en, gval;
   logic [15:0] count;
   int          n_errors  = 0;
   int          tests_run = 0;
   gbt_note_t   notes[$];
   gbt_note_t   nt;

   // The clock toggles every 2 ns, a full period of 4 ns.
   always #2 clock_i = ~clock_i;

   gbt_timer i_dut (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .ext_clk_i(ext_clk),
      .lfosc_i(lfosc), .sosc_clk_i(sosc), .gate_pin_i(gpin),
      .cmp1_i(cmp1), .cmp2_i(cmp2), .wrap_pulse_i(wrap),
      .sleep_i(sleep), .sosc_enable_o(sosc_en), .count_o(count),
      .gate_value_o(gval));

   gbt_far_model i_far (.clock_i(clock_i), .ext_clk_o(ext_clk),
      .lfosc_o(lfosc), .sosc_o(sosc), .gate_o(gpin), .cmp1_o(cmp1),
      .cmp2_o(cmp2), .wrap_o(wrap));

   task automatic fail(input string m);
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask : fail

   task automatic complete_run;
      repeat (2) @(posedge clock_i);
      if (notes.size() != 0) begin
         fail("read expectation left unused");
      end
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail("port value differs");
      end
   endtask : chk

   // One APB transfer, held until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clock_i);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail("no pready");
         complete_run();
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] lo,
                     input logic [31:0] hi, input logic err);
      notes.push_back('{lo, hi, err});
      apb(1'b0, a, 32'h0);
   endtask : rd

   // Stops the counter before writing it, clears it and starts it.
   task automatic start_run(input logic [7:0] c);
      wr(gbt_pkg::ADDR_CTRL, c & 8'hfe);
      wr(gbt_pkg::ADDR_LOW, 8'h00);
      wr(gbt_pkg::ADDR_HIGH, 8'h00);
      wr(gbt_pkg::ADDR_CTRL, c | 8'h01);
   endtask : start_run

   task automatic stop_check(input logic [7:0] c, input int lo,
                             input int hi);
      wr(gbt_pkg::ADDR_CTRL, c & 8'hfe);
      rd(gbt_pkg::ADDR_LOW, lo, hi, 1'b0);
      rd(gbt_pkg::ADDR_HIGH, 0, 0, 1'b0);
   endtask : stop_check

   // Each completed read is compared with the oldest noted expectation.
   always @(posedge clock_i) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         tests_run++;
         if (notes.size() == 0) begin
            fail("read without expectation");
         end else begin
            nt = notes.pop_front();
            if ((prdata >= nt.lo) !== 1'b1 || (prdata <= nt.hi) !== 1'b1
                || pslverr !== nt.err) begin
               fail("read data or error flag differs");
            end
         end
      end
   end

   // Main sequence: reset, then one scenario after another.
   initial begin
      logic [7:0] c, v;
      logic [1:0] s;
      logic       p;
      int         k, d;
      void'($urandom(32'h8bbdb7c5));
      repeat (6) @(posedge clock_i);
      srst_i <= 1'b0;
      rd(gbt_pkg::ADDR_CTRL, 0, 0, 1'b0);
      rd(gbt_pkg::ADDR_HIGH, 0, 0, 1'b0);
      rd(8'h40, 0, 0, 1'b1);
      v = 8'($urandom());
      wr(gbt_pkg::ADDR_LOW, v);
      wr(gbt_pkg::ADDR_HIGH, ~v);
      @(negedge clock_i);
      chk(count, {~v, v});
      rd(gbt_pkg::ADDR_LOW, v, v, 1'b0);
      // Instruction rate and system clock through every prescale.
      for (k = 0; k < 8; k++) begin
         c = {k[2] ? 2'h1 : 2'h0, 2'(k), 4'h0};
         d = (k[2] ? 1 : 4) << k[1:0];
         start_run(c);
         repeat (200) @(posedge clock_i);
         stop_check(c, 200 / d, 206 / d + 1);
      end
      // Overflow from a preset of FC00h after 1024 counts.
      wr(gbt_pkg::ADDR_FLAGS, 8'h03);
      wr(gbt_pkg::ADDR_CTRL, 8'h40);
      wr(gbt_pkg::ADDR_LOW, 8'h00);
      wr(gbt_pkg::ADDR_HIGH, 8'hfc);
      wr(gbt_pkg::ADDR_CTRL, 8'h41);
      repeat (1012) @(posedge clock_i);
      rd(gbt_pkg::ADDR_FLAGS, 0, 0, 1'b0);
      repeat (14) @(posedge clock_i);
      rd(gbt_pkg::ADDR_FLAGS, 1, 1, 1'b0);
      rd(gbt_pkg::ADDR_HIGH, 0, 0, 1'b0);
      wr(gbt_pkg::ADDR_FLAGS, 8'h03);
      rd(gbt_pkg::ADDR_FLAGS, 0, 0, 1'b0);
      // External pin: awake, asleep with sync bit set, asleep without.
      for (k = 0; k < 3; k++) begin
         d = 1 + $urandom_range(15);
         c = (k == 1) ? 8'h84 : 8'h80;
         start_run(c);
         sleep <= (k > 0);
         i_far.pulses(0, d, k + 2);
         repeat (6) @(posedge clock_i);
         sleep <= 1'b0;
         stop_check(c, k == 2 ? 0 : d, k == 2 ? 0 : d);
      end
      start_run(8'hc0);
      i_far.pulses(1, 9, 5);
      stop_check(8'hc0, 9, 9);
      start_run(8'h8a);
      sleep <= 1'b1;
      @(posedge clock_i);
      chk({15'h0, sosc_en}, 16'h0001);
      sleep <= 1'b0;
      i_far.pulses(2, 7, 3);
      stop_check(8'h8a, 7, 7);
      // Clock enable low freezes the running counter for 30 cycles.
      start_run(8'h40);
      repeat (20) @(posedge clock_i);
      ce <= 1'b0;
      repeat (30) @(posedge clock_i);
      ce <= 1'b1;
      stop_check(8'h40, 22, 26);
      // Gated counting over pin and comparators at both polarities.
      for (k = 0; k < 6; k++) begin
         s = (k % 3 == 0) ? 2'h0 : 2'(k % 3 + 1);
         p = (k > 2);
         if (k == 3) begin
            wr(gbt_pkg::ADDR_CSYNC, 8'h03);
         end
         i_far.level(3 + k % 3, ~p);
         wr(gbt_pkg::ADDR_GATE, {1'b1, p, 4'h0, s});
         start_run(8'h40);
         repeat (40) @(posedge clock_i);
         i_far.level(3 + k % 3, p);
         repeat (50) @(posedge clock_i);
         stop_check(8'h40, 45, 56);
         i_far.level(3 + k % 3, ~p);
      end
      rd(gbt_pkg::ADDR_CSYNC, 3, 3, 1'b0);
      // Gate value with gating off, then its falling edge.
      wr(gbt_pkg::ADDR_FLAGS, 8'h03);
      wr(gbt_pkg::ADDR_GATE, 8'h40);
      i_far.level(3, 1'b1);
      repeat (4) @(posedge clock_i);
      chk({15'h0, gval}, 16'h0001);
      rd(gbt_pkg::ADDR_GATE, 8'h44, 8'h44, 1'b0);
      i_far.level(3, 1'b0);
      repeat (4) @(posedge clock_i);
      chk({15'h0, gval}, 16'h0000);
      rd(gbt_pkg::ADDR_FLAGS, 2, 2, 1'b0);
      // Toggle mode on the wrap pulse: one wrap to the next.
      wr(gbt_pkg::ADDR_GATE, 8'he1);
      start_run(8'h40);
      i_far.wrap_pulse();
      repeat (30) @(posedge clock_i);
      i_far.wrap_pulse();
      repeat (30) @(posedge clock_i);
      stop_check(8'h40, 26, 34);
      // Single pulse, then single pulse with toggle.
      wr(gbt_pkg::ADDR_GATE, 8'hd8);
      start_run(8'h40);
      i_far.pulses(3, 2, 20);
      rd(gbt_pkg::ADDR_GATE, 8'hd0, 8'hd0, 1'b0);
      stop_check(8'h40, 17, 23);
      wr(gbt_pkg::ADDR_GATE, 8'h00);
      wr(gbt_pkg::ADDR_GATE, 8'hf8);
      start_run(8'h40);
      i_far.pulses(3, 3, 10);
      stop_check(8'h40, 17, 23);
      complete_run();
   end
endmodule : testbench
